/* File: shared/dsk_pkg.sv */
// Constants and codes shared by the disk command link.
// Assumes one clock for both ends of the link and an active low asynchronous reset.
// Summary of operation
// - Opcode 35h selects extended DMA write.
// - DMA write data moves as 16-bit words.
// - Host prepares DMA before writing opcode.
// - DMA words move only while request asserted.
// - One completion interrupt per DMA write.
// - Uncorrectable error stops at failing sector.
// - 16-bit sector count; zero means 65536.
// - 48-bit address from current/previous byte pairs.
// - Failing address readable, high select picks half.
// - Fault bit zero; ready, seek, error valid.
// - Opcodes 32h/33h select long write; bit0 retry.
// - Long write records one sector plus ECC.
// - Host loads sector count one for long.
// - Data request stays set until ECC delivered.
// - Long data words 16-bit, ECC bytes 8-bit.
// - ECC length 4 or 40 by feature.
// - ECC length defaults to four after reset.
// - 28-bit address: low, mid, high, head nibble.
// - Retry bit ignored; identical execution.
// - Long completion returns remaining count and address.
// - Media always gets 40 ECC bytes; pad emulated.
// - Host prefers 40-byte mode for ECC tests.
package dsk_pkg;
    localparam logic [3:0] A_DATA     = 4'h0;
    localparam logic [3:0] A_FEAT_ERR = 4'h1;
    localparam logic [3:0] A_COUNT    = 4'h2;
    localparam logic [3:0] A_LOW      = 4'h3;
    localparam logic [3:0] A_MID      = 4'h4;
    localparam logic [3:0] A_HIGH     = 4'h5;
    localparam logic [3:0] A_DEV      = 4'h6;
    localparam logic [3:0] A_CMD_STAT = 4'h7;
    localparam logic [3:0] A_CTL      = 4'h8;
    localparam int         CTL_HOB    = 7;
    localparam int         DEV_L      = 6;

    localparam logic [7:0] OP_DMA_EXT = 8'h35;
    localparam logic [6:0] OP_LONG_HI = 7'h19;
    localparam logic [7:0] OP_LONG    = 8'h32;
    localparam logic [7:0] OP_SETFEAT = 8'hEF;
    localparam logic [7:0] FT_ECC40   = 8'h44;
    localparam logic [7:0] FT_ECC4    = 8'hBB;

    localparam int ERR_ICRC = 7;
    localparam int ERR_IDNF = 4;
    localparam int ERR_ABRT = 2;

    localparam logic [8:0]  WORDS_LAST  = 9'h0FF;
    localparam logic [8:0]  ECC_SHORT   = 9'h004;
    localparam logic [8:0]  ECC_LONG    = 9'h028;
    localparam logic [16:0] CNT_MAX     = 17'h10000;
    localparam logic        ECC40_RESET = 1'b0;
    localparam logic [3:0]  TF_STEPS    = 4'hA;

    localparam logic [7:0] R_CTRL   = 8'h00;
    localparam logic [7:0] R_LBA_LO = 8'h04;
    localparam logic [7:0] R_LBA_HI = 8'h08;
    localparam logic [7:0] R_COUNT  = 8'h0C;
    localparam logic [7:0] R_STATUS = 8'h10;
    localparam int         CTRL_L   = 16;
endpackage

/* File: shared/dsk_if.sv */
// Link between the host controller and the disk device.
// Assumes both ends share pclk; all signals are synchronous to it.
`timescale 1ns/1ps
interface dsk_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        data_req;
    logic        dmarq;
    logic        dmack;
    logic        intrq;
    modport dev  (input wr_stb, rd_stb, addr, wdata, dmack,
                  output rdata, data_req, dmarq, intrq);
    modport host (output wr_stb, rd_stb, addr, wdata, dmack,
                  input rdata, data_req, dmarq, intrq);
endinterface

/* File: rtl/dsk_device.sv */
// Disk device end: task file, extended DMA write, long write, ECC length feature.
// Assumes the host keeps its own protocol duties; media accepts one item per clock.
`timescale 1ns/1ps
module dsk_device
    import dsk_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    dsk_if.dev               link,
    output logic             med_valid,
    output logic [15:0]      med_data,
    output logic             med_ecc,
    output logic [47:0]      med_lba,
    input  wire logic        med_fail
);
    import dsk_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DMA  = 3'b001,
        S_LDAT = 3'b011,
        S_LECC = 3'b010,
        S_LPAD = 3'b110
    } dstate_e;

    typedef struct packed {
        dstate_e     st;
        logic [7:0]  fc;
        logic [7:0]  sc;
        logic [7:0]  sp;
        logic [7:0]  ll;
        logic [7:0]  lp;
        logic [7:0]  ml;
        logic [7:0]  mp;
        logic [7:0]  hl;
        logic [7:0]  hp;
        logic [7:0]  dev;
        logic        hob;
        logic        ecc40;
        logic [16:0] cnt;
        logic [8:0]  wcnt;
        logic [47:0] lba;
        logic [7:0]  errb;
        logic        err;
        logic        intrq;
        logic        drq;
        logic [15:0] rdata;
        logic        mv;
        logic [15:0] md;
        logic        me;
        logic [47:0] ml48;
    } dstate_s;

    dstate_s s_reg;
    dstate_s s_next;
    logic [7:0] status;
    logic [8:0] ecc_last;

    assign status = {s_reg.st != S_IDLE, 1'b1, 1'b0, 1'b1,
                     s_reg.drq, 1'b0, 1'b0, s_reg.err};
    assign ecc_last = (s_reg.ecc40 ? ECC_LONG : ECC_SHORT) - 9'h001;

    always_comb begin
        s_next = s_reg;
        s_next.mv = 1'b0;
        if (link.rd_stb) begin
            unique case (link.addr)
                A_FEAT_ERR: s_next.rdata = {8'h00, s_reg.errb};
                A_COUNT:    s_next.rdata = {8'h00, s_reg.hob ? s_reg.sp : s_reg.sc};
                A_LOW:      s_next.rdata = {8'h00, s_reg.hob ? s_reg.lp : s_reg.ll};
                A_MID:      s_next.rdata = {8'h00, s_reg.hob ? s_reg.mp : s_reg.ml};
                A_HIGH:     s_next.rdata = {8'h00, s_reg.hob ? s_reg.hp : s_reg.hl};
                A_DEV:      s_next.rdata = {8'h00, s_reg.dev};
                A_CMD_STAT: begin
                    s_next.rdata = {8'h00, status};
                    s_next.intrq = 1'b0;
                end
                default:    s_next.rdata = 16'h0000;
            endcase
        end
        if (link.wr_stb && s_reg.st == S_IDLE) begin
            unique case (link.addr)
                A_FEAT_ERR: s_next.fc = link.wdata[7:0];
                A_COUNT: begin
                    s_next.sp = s_reg.sc;
                    s_next.sc = link.wdata[7:0];
                end
                A_LOW: begin
                    s_next.lp = s_reg.ll;
                    s_next.ll = link.wdata[7:0];
                end
                A_MID: begin
                    s_next.mp = s_reg.ml;
                    s_next.ml = link.wdata[7:0];
                end
                A_HIGH: begin
                    s_next.hp = s_reg.hl;
                    s_next.hl = link.wdata[7:0];
                end
                A_DEV:      s_next.dev = link.wdata[7:0];
                A_CTL:      s_next.hob = link.wdata[CTL_HOB];
                A_CMD_STAT: begin
                    s_next.intrq = 1'b0;
                    s_next.err = 1'b0;
                    s_next.errb = 8'h00;
                    s_next.wcnt = 9'h000;
                    s_next.hob = 1'b0;
                    if (link.wdata[7:0] == OP_DMA_EXT) begin
                        s_next.st = S_DMA;
                        s_next.cnt = ({s_reg.sp, s_reg.sc} == 16'h0000) ? CNT_MAX
                                   : {1'b0, s_reg.sp, s_reg.sc};
                        s_next.lba = {s_reg.hp, s_reg.mp, s_reg.lp,
                                      s_reg.hl, s_reg.ml, s_reg.ll};
                    end else if (link.wdata[7:1] == OP_LONG_HI) begin
                        s_next.lba = {20'h00000, s_reg.dev[3:0],
                                      s_reg.hl, s_reg.ml, s_reg.ll};
                        s_next.cnt = 17'h00001;
                        if (s_reg.sc == 8'h01) begin
                            s_next.st = S_LDAT;
                            s_next.drq = 1'b1;
                        end else begin
                            s_next.err = 1'b1;
                            s_next.errb[ERR_ABRT] = 1'b1;
                            s_next.intrq = 1'b1;
                        end
                    end else if (link.wdata[7:0] == OP_SETFEAT && s_reg.fc == FT_ECC40) begin
                        s_next.ecc40 = 1'b1;
                        s_next.intrq = 1'b1;
                    end else if (link.wdata[7:0] == OP_SETFEAT && s_reg.fc == FT_ECC4) begin
                        s_next.ecc40 = 1'b0;
                        s_next.intrq = 1'b1;
                    end else begin
                        s_next.err = 1'b1;
                        s_next.errb[ERR_ABRT] = 1'b1;
                        s_next.intrq = 1'b1;
                    end
                end
                default: s_next.rdata = s_next.rdata;
            endcase
        end
        unique case (s_reg.st)
            S_IDLE: s_next.drq = s_next.drq;
            S_DMA: begin
                if (link.dmack) begin
                    s_next.mv = 1'b1;
                    s_next.md = link.wdata;
                    s_next.me = 1'b0;
                    s_next.ml48 = s_reg.lba;
                    s_next.wcnt = s_reg.wcnt + 9'h001;
                    if (s_reg.wcnt == WORDS_LAST) begin
                        s_next.wcnt = 9'h000;
                        if (med_fail) begin
                            s_next.st = S_IDLE;
                            s_next.err = 1'b1;
                            s_next.errb[ERR_IDNF] = 1'b1;
                            s_next.intrq = 1'b1;
                            s_next.sc = s_reg.cnt[7:0];
                            s_next.sp = s_reg.cnt[15:8];
                            {s_next.hp, s_next.mp, s_next.lp,
                             s_next.hl, s_next.ml, s_next.ll} = s_reg.lba;
                        end else if (s_reg.cnt == 17'h00001) begin
                            s_next.st = S_IDLE;
                            s_next.intrq = 1'b1;
                            s_next.sc = 8'h00;
                            s_next.sp = 8'h00;
                            {s_next.hp, s_next.mp, s_next.lp,
                             s_next.hl, s_next.ml, s_next.ll} = s_reg.lba;
                        end else begin
                            s_next.cnt = s_reg.cnt - 17'h00001;
                            s_next.lba = s_reg.lba + 48'h000000000001;
                        end
                    end
                end
            end
            S_LDAT: begin
                if (link.wr_stb && link.addr == A_DATA) begin
                    s_next.mv = 1'b1;
                    s_next.md = link.wdata;
                    s_next.me = 1'b0;
                    s_next.ml48 = s_reg.lba;
                    s_next.wcnt = s_reg.wcnt + 9'h001;
                    if (s_reg.wcnt == WORDS_LAST) begin
                        s_next.st = S_LECC;
                        s_next.wcnt = 9'h000;
                    end
                end
            end
            S_LECC: begin
                if (link.wr_stb && link.addr == A_DATA) begin
                    s_next.mv = 1'b1;
                    s_next.md = {8'h00, link.wdata[7:0]};
                    s_next.me = 1'b1;
                    s_next.wcnt = s_reg.wcnt + 9'h001;
                    if (s_reg.wcnt == ecc_last) begin
                        s_next.drq = 1'b0;
                        s_next.st = s_reg.ecc40 ? S_IDLE : S_LPAD;
                    end
                end
            end
            S_LPAD: begin
                s_next.mv = 1'b1;
                s_next.md = 16'h0000;
                s_next.me = 1'b1;
                s_next.wcnt = s_reg.wcnt + 9'h001;
                if (s_reg.wcnt == ECC_LONG - 9'h001) begin
                    s_next.st = S_IDLE;
                end
            end
            default: s_next.st = S_IDLE;
        endcase
        if (s_reg.st inside {S_LECC, S_LPAD} && s_next.st == S_IDLE) begin
            s_next.intrq = 1'b1;
            s_next.sc = 8'h00;
            s_next.ll = s_reg.lba[7:0];
            s_next.ml = s_reg.lba[15:8];
            s_next.hl = s_reg.lba[23:16];
            s_next.dev = {s_reg.dev[7:4], s_reg.lba[27:24]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.ecc40 <= ECC40_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.rdata    = s_reg.rdata;
    assign link.data_req = s_reg.drq;
    assign link.dmarq    = (s_reg.st == S_DMA);
    assign link.intrq    = s_reg.intrq;
    assign med_valid     = s_reg.mv;
    assign med_data      = s_reg.md;
    assign med_ecc       = s_reg.me;
    assign med_lba       = s_reg.ml48;
endmodule

/* File: rtl/dsk_host.sv */
// Host controller end: APB slave for software, task file loader, DMA and PIO data mover.
// Assumes a word source that may stall, and the device on the link interface.
`timescale 1ns/1ps
module dsk_host
    import dsk_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] src_data,
    input  wire logic        src_valid,
    output logic             src_ready,
    dsk_if.host              link
);
    import dsk_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_TF   = 3'b001,
        H_XFER = 3'b011,
        H_RST  = 3'b010,
        H_RER  = 3'b110,
        H_RSC  = 3'b111,
        H_CAP  = 3'b101
    } hstate_e;

    typedef struct packed {
        hstate_e     st;
        logic [31:0] ctrl;
        logic [31:0] lba_lo;
        logic [15:0] lba_hi;
        logic [15:0] count;
        logic [7:0]  stat;
        logic [7:0]  errb;
        logic [7:0]  rcnt;
        logic        done;
        logic [3:0]  step;
    } hstate_s;

    hstate_s s_reg;
    hstate_s s_next;
    logic [3:0]  tf_addr;
    logic [7:0]  tf_data;
    logic        is_dma;
    logic        is_pio;
    logic        acc;
    logic        mapped;
    logic [47:0] lba;

    assign lba    = {s_reg.lba_hi, s_reg.lba_lo};
    assign is_dma = s_reg.ctrl[7:0] == OP_DMA_EXT;
    assign is_pio = s_reg.ctrl[7:1] == OP_LONG_HI;
    assign acc    = psel && penable;
    assign mapped = paddr inside {R_CTRL, R_LBA_LO, R_LBA_HI, R_COUNT, R_STATUS};

    always_comb begin
        unique case (s_reg.step)
            4'h0:    {tf_addr, tf_data} = {A_FEAT_ERR, s_reg.ctrl[15:8]};
            4'h1:    {tf_addr, tf_data} = {A_COUNT, s_reg.count[15:8]};
            4'h2:    {tf_addr, tf_data} = {A_COUNT, s_reg.count[7:0]};
            4'h3:    {tf_addr, tf_data} = {A_LOW, lba[31:24]};
            4'h4:    {tf_addr, tf_data} = {A_LOW, lba[7:0]};
            4'h5:    {tf_addr, tf_data} = {A_MID, lba[39:32]};
            4'h6:    {tf_addr, tf_data} = {A_MID, lba[15:8]};
            4'h7:    {tf_addr, tf_data} = {A_HIGH, lba[47:40]};
            4'h8:    {tf_addr, tf_data} = {A_HIGH, lba[23:16]};
            4'h9:    {tf_addr, tf_data} = {A_DEV, 1'b1, s_reg.ctrl[CTRL_L], 2'b10,
                                           lba[27:24]};
            4'hA:    {tf_addr, tf_data} = {A_CMD_STAT, s_reg.ctrl[7:0]};
            default: {tf_addr, tf_data} = {A_DATA, 8'h00};
        endcase
    end

    always_comb begin
        link.dmack  = s_reg.st == H_XFER && is_dma && link.dmarq && src_valid;
        link.wr_stb = s_reg.st == H_TF
                   || (s_reg.st == H_XFER && is_pio && link.data_req && src_valid);
        link.rd_stb = s_reg.st inside {H_RST, H_RER, H_RSC};
        src_ready   = link.dmack || (s_reg.st == H_XFER && link.wr_stb);
        link.wdata  = s_reg.st == H_TF ? {8'h00, tf_data} : src_data;
        unique case (s_reg.st)
            H_RST:   link.addr = A_CMD_STAT;
            H_RER:   link.addr = A_FEAT_ERR;
            H_RSC:   link.addr = A_COUNT;
            H_TF:    link.addr = tf_addr;
            default: link.addr = A_DATA;
        endcase
        pready  = 1'b1;
        pslverr = acc && !mapped;
        unique case (paddr)
            R_CTRL:   prdata = s_reg.ctrl;
            R_LBA_LO: prdata = s_reg.lba_lo;
            R_LBA_HI: prdata = {16'h0000, s_reg.lba_hi};
            R_COUNT:  prdata = {16'h0000, s_reg.count};
            R_STATUS: prdata = {s_reg.rcnt, 6'h00, s_reg.done, s_reg.st != H_IDLE,
                                s_reg.errb, s_reg.stat};
            default:  prdata = 32'h00000000;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        if (acc && pwrite && s_reg.st == H_IDLE) begin
            unique case (paddr)
                R_CTRL: begin
                    s_next.ctrl = pwdata;
                    s_next.st = H_TF;
                    s_next.step = 4'h0;
                    s_next.done = 1'b0;
                end
                R_LBA_LO: s_next.lba_lo = pwdata;
                R_LBA_HI: s_next.lba_hi = pwdata[15:0];
                R_COUNT:  s_next.count = pwdata[15:0];
                default:  s_next.done = s_reg.done;
            endcase
        end
        unique case (s_reg.st)
            H_IDLE: s_next.step = s_next.step;
            H_TF: begin
                s_next.step = s_reg.step + 4'h1;
                if (s_reg.step == TF_STEPS) begin
                    s_next.st = H_XFER;
                end
            end
            H_XFER: if (link.intrq) s_next.st = H_RST;
            H_RST:  s_next.st = H_RER;
            H_RER: begin
                s_next.stat = link.rdata[7:0];
                s_next.st = H_RSC;
            end
            H_RSC: begin
                s_next.errb = link.rdata[7:0];
                s_next.st = H_CAP;
            end
            H_CAP: begin
                s_next.rcnt = link.rdata[7:0];
                s_next.done = 1'b1;
                s_next.st = H_IDLE;
            end
            default: s_next.st = H_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: dv/dsk_link_asserts.sv */
// Concurrent checks on the link between the host controller and the disk device.
// Assumes every link signal is synchronous to pclk and presetn is active low.
`timescale 1ns/1ps
module dsk_link_asserts
    import dsk_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        data_req,
    input wire logic        dmarq,
    input wire logic        dmack,
    input wire logic        intrq
);
    import dsk_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic cmd_wr  = wr_stb && addr == A_CMD_STAT;
    wire logic stat_rd = rd_stb && addr == A_CMD_STAT;

    dma_start_a: assert property (cmd_wr && wdata[7:0] == OP_DMA_EXT |=> dmarq)
        else $error("dma request missing after dma command");
    long_start_a: assert property (
        cmd_wr && wdata[7:1] == OP_LONG_HI |=> data_req || intrq)
        else $error("long write neither requested data nor completed");
    dma_gate_a: assert property (dmack |-> dmarq)
        else $error("dma word moved without request");
    dma_hold_a: assert property (dmarq && !dmack |=> dmarq)
        else $error("dma request dropped without a word");
    drq_hold_a: assert property (data_req && !(wr_stb && addr == A_DATA) |=> data_req)
        else $error("data request dropped before data delivered");
    intr_end_a: assert property ($rose(intrq) |-> !dmarq && !data_req)
        else $error("interrupt raised while transfer still open");
    intr_hold_a: assert property (intrq && !stat_rd && !cmd_wr |=> intrq)
        else $error("interrupt cleared without status read");
    status_fix_a: assert property (
        stat_rd |=> rdata[6:4] == 3'b101 && rdata[15:8] == 8'h00)
        else $error("status fixed bits wrong");
    busy_clear_a: assert property (intrq && stat_rd |=> !rdata[7])
        else $error("busy still set with interrupt");

    cover property ($rose(dmarq));
    cover property ($rose(data_req));
    cover property ($fell(intrq));
endmodule

/* File: dv/disk_ext_dma_and_long_write_test.sv */
// Self-checking bench joining host and device ends, driven over APB.
// Assumes a 100 MHz pclk and a word source that offers data every other cycle.
`timescale 1ns/1ps
module disk_ext_dma_and_long_write_test;
    import dsk_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, st;
    logic [15:0] src_data, med_data, first_src, first_med;
    logic        src_valid, src_ready, med_valid, med_ecc, med_fail, fail_on;
    logic [47:0] med_lba, first_lba;
    int          dat_n, ecc_n, src_n, compares, fail_count;

    dsk_if link();
    dsk_device u_dsk_device (.pclk(pclk), .presetn(presetn), .link(link), .med_valid(med_valid),
        .med_data(med_data), .med_ecc(med_ecc), .med_lba(med_lba), .med_fail(med_fail));
    dsk_host u_dsk_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
        .link(link));
    dsk_link_asserts u_dsk_link_asserts (.pclk(pclk), .presetn(presetn), .wr_stb(link.wr_stb),
        .rd_stb(link.rd_stb), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .data_req(link.data_req), .dmarq(link.dmarq), .dmack(link.dmack), .intrq(link.intrq));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Source stalls every other cycle; media and source traffic are counted.
    always @(posedge pclk) begin
        src_valid <= ~src_valid;
        med_fail  <= fail_on;
        if (src_ready === 1'b1 && src_valid === 1'b1) begin
            if (src_n == 0) first_src <= src_data;
            src_data <= src_data + 16'h0001;
            src_n    <= src_n + 1;
        end
        if (med_valid === 1'b1 && med_ecc === 1'b1) ecc_n <= ecc_n + 1;
        if (med_valid === 1'b1 && med_ecc === 1'b0) begin
            if (dat_n == 0) begin
                first_lba <= med_lba;
                first_med <= med_data;
            end
            dat_n <= dat_n + 1;
        end
    end

    task end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string n, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int   i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                q      = prdata;
                slverr = pslverr;
                break;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            fail_count++;
            $display("MISMATCH pready expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic run_cmd(input logic [7:0] op, input logic [7:0] ft, input logic lm,
                           input logic [47:0] lba, input logic [15:0] cnt);
        int k;
        dat_n = 0;
        ecc_n = 0;
        src_n = 0;
        apb(1'b1, R_LBA_LO, lba[31:0], st);
        apb(1'b1, R_LBA_HI, {16'h0000, lba[47:32]}, st);
        apb(1'b1, R_COUNT, {16'h0000, cnt}, st);
        apb(1'b1, R_CTRL, {15'h0000, lm, ft, op}, st);
        for (k = 0; k < 4000; k++) begin
            apb(1'b0, R_STATUS, 32'h0000_0000, st);
            if (st[17:16] === 2'b10) break;
        end
        if (k == 4000) begin
            fail_count++;
            $display("MISMATCH done expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic res(input string n, input int d, input int e, input int s,
                       input logic [7:0] sv, input logic [7:0] ev);
        check({n, " data items"}, 48'(d), 48'(dat_n));
        check({n, " ecc items"}, 48'(e), 48'(ecc_n));
        check({n, " source items"}, 48'(s), 48'(src_n));
        check({n, " status"}, {40'h0, sv}, {40'h0, st[7:0]});
        check({n, " error"}, {40'h0, ev}, {40'h0, st[15:8]});
        $display("test %s done", n);
    endtask

    initial begin
        {psel, penable, pwrite, med_fail, fail_on, src_valid, presetn} = 7'h00;
        {paddr, pwdata, src_data} = 56'h00_0000_0000_1000;
        {dat_n, ecc_n, src_n, compares, fail_count} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, R_STATUS, 32'h0, st);
        check("idle flags", 48'h0, {46'h0, st[17:16]});
        apb(1'b0, 8'h20, 32'h0, st);
        check("unmapped err", 48'h1, {47'h0, slverr});
        check("unmapped data", 48'h0, {16'h0, st});
        run_cmd(OP_DMA_EXT, 8'h00, 1'b1, 48'hA1B2C3D4E5F6, 16'h0002);
        res("dma", 512, 0, 512, 8'h50, 8'h00);
        check("dma lba", 48'hA1B2C3D4E5F6, first_lba);
        check("dma word", {32'h0, first_src}, {32'h0, first_med});
        check("dma left", 48'h0, {40'h0, st[31:24]});
        fail_on = 1'b1;
        run_cmd(OP_DMA_EXT, 8'h00, 1'b1, 48'h000012345600, 16'h0003);
        fail_on = 1'b0;
        res("dma fail", 256, 0, 256, 8'h51, 8'h10);
        check("fail lba", 48'h000012345600, first_lba);
        check("fail left", 48'h3, {40'h0, st[31:24]});
        fail_on = 1'b1;
        run_cmd(OP_DMA_EXT, 8'h00, 1'b1, 48'h0, 16'h0000);
        fail_on = 1'b0;
        res("dma zero", 256, 0, 256, 8'h51, 8'h10);
        check("zero left", 48'h0, {40'h0, st[31:24]});
        run_cmd(OP_LONG, 8'h00, 1'b1, 48'h000009ABCDEF, 16'h0001);
        res("long4", 256, 40, 260, 8'h50, 8'h00);
        check("long lba", 48'h000009ABCDEF, first_lba);
        check("long left", 48'h0, {40'h0, st[31:24]});
        run_cmd(OP_SETFEAT, FT_ECC40, 1'b1, 48'h0, 16'h0001);
        check("feature status", 48'h50, {40'h0, st[7:0]});
        run_cmd(OP_LONG | 8'h01, 8'h00, 1'b1, 48'h000000000777, 16'h0001);
        res("long40", 256, 40, 296, 8'h50, 8'h00);
        run_cmd(OP_LONG, 8'h00, 1'b1, 48'h0, 16'h0002);
        check("abort error", 48'h04, {40'h0, st[15:8]});
        check("abort status", 48'h51, {40'h0, st[7:0]});
        $display("test abort done");
        run_cmd(OP_SETFEAT, FT_ECC4, 1'b1, 48'h0, 16'h0001);
        check("feature4 status", 48'h50, {40'h0, st[7:0]});
        run_cmd(OP_LONG, 8'h00, 1'b1, 48'h000000000123, 16'h0001);
        res("long4 again", 256, 40, 260, 8'h50, 8'h00);
        end_sim();
    end
endmodule
